// ---- pkg/timing_guard_pkg.sv ----
// constants, field layouts and carrier structs for the command timing guard
// assumes a scheduler that offers one command per cycle and honours its grant
// Behaviour
// - after activate then write with page close, hold same-bank activate for that spacing
// - bits 19:14 set activate to activate or refresh spacing, same bank
// - bits 13:6 set refresh to any activate or refresh spacing
// - bits 5:2 set activate to activate or refresh spacing, other bank
// - bits 1:0 set average refresh spacing in 3.9 us steps
// - refresh interval zero stops refresh and keeps its counter clear
// - all spacings but the refresh interval count core clock cycles, not frame periods
// - second register bits 18:16 set write to read spacing, other rank
`default_nettype none
package timing_guard_pkg;
  localparam int RANKS = 4;
  localparam int BANKS = 8;
  localparam logic [7:0] TIMING_A_OFFSET = 8'h48;
  localparam logic [7:0] TIMING_B_OFFSET = 8'h4c;
  localparam logic [31:0] TIMING_A_RESET = 32'h0000_0000;
  localparam logic [31:0] TIMING_B_RESET = 32'h0000_0000;
  localparam logic [31:0] TIMING_A_RW_MASK = 32'h7fff_ffff;
  localparam logic [31:0] TIMING_B_RW_MASK = 32'h0007_ffff;
  localparam int WRC_LSB = 20;
  localparam int ROW_LSB = 14;
  localparam int RFC_LSB = 6;
  localparam int RRD_LSB = 2;
  localparam int REF_LSB = 0;
  localparam int W2R_LSB = 16;
  localparam int REF_STEP_NS = 3900;
  localparam int CLK_PERIOD_NS = 10;
  localparam int REF_STEP_CYCLES = REF_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    CMD_ACT   = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_READ  = 3'h3,
    CMD_REF   = 3'h4
  } dram_cmd_e;

  typedef struct packed
  {
    logic       valid;
    dram_cmd_e  cmd;
    logic [1:0] rank;
    logic [2:0] bank;
    logic       auto_close;
  } cmd_req_s;
endpackage
`default_nettype wire

// ---- rtl/dram_command_timing_guard.sv ----
// per-bank/per-rank spacing counters and refresh pacing for a cmd scheduler
// assumes register writes arrive as single-cycle strobes on the core clock
`timescale 1ns/1ps
`default_nettype none
module dram_command_timing_guard
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic                        reg_wr,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  output logic      [31:0]                 reg_rdata,
  input  wire timing_guard_pkg::cmd_req_s  req,
  output logic                             grant,
  output logic      [3:0]                  refresh_due
);
  import timing_guard_pkg::*;

  // both timing words live here; software loads them once after
  // reading module presence data, before any traffic is offered.
  // changing a field other than the refresh interval mid-traffic only affects later reloads, so a
  // counter already running keeps the old spacing to its end
  logic [31:0] dram_bank_timing_a_reg;
  logic [31:0] ddr_turnaround_timing_b_reg;
  logic [31:0] rdata_next;

  // field views, all but the refresh interval (3.9 us steps) counted in core cycles
  wire [5:0] write_recovery_cycle_spacing =
    dram_bank_timing_a_reg[WRC_LSB +: 6];
  wire [5:0] same_bank_row_cycle = dram_bank_timing_a_reg[ROW_LSB +: 6];
  wire [7:0] refresh_cycle_spacing = dram_bank_timing_a_reg[RFC_LSB +: 8];
  wire [3:0] bank_to_bank_spacing = dram_bank_timing_a_reg[RRD_LSB +: 4];
  wire [1:0] refresh_interval = dram_bank_timing_a_reg[REF_LSB +: 2];
  wire [2:0] write_read_other_rank_spacing =
    ddr_turnaround_timing_b_reg[W2R_LSB +: 3];

  // register decode
  // read data is registered, so a read shows one cycle after the
  // address; unmapped offsets read zero and ignore writes
  wire sel_a = reg_addr == TIMING_A_OFFSET;
  wire sel_b = reg_addr == TIMING_B_OFFSET;
  assign rdata_next = sel_a ? dram_bank_timing_a_reg :
                      sel_b ? ddr_turnaround_timing_b_reg : 32'h0;

  // reserved bits stay zero by masking on write
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      dram_bank_timing_a_reg      <= TIMING_A_RESET;
      ddr_turnaround_timing_b_reg <= TIMING_B_RESET;
      reg_rdata                   <= 32'h0;
    end
    else
    begin
      if (reg_wr && sel_a)
        dram_bank_timing_a_reg <= reg_wdata & TIMING_A_RW_MASK;
      if (reg_wr && sel_b)
        ddr_turnaround_timing_b_reg <= reg_wdata & TIMING_B_RW_MASK;
      reg_rdata <= rdata_next;
    end
  end

  // counters; bank timer holds the larger of row cycle and write recovery
  logic [7:0] bank_cnt_reg [RANKS][BANKS];
  logic       act_open_reg [RANKS][BANKS];
  logic [7:0] rank_act_cnt_reg [RANKS];
  logic [7:0] rank_ref_cnt_reg [RANKS];
  logic [7:0] rank_w2r_cnt_reg [RANKS];

  wire is_act   = req.cmd == CMD_ACT;
  wire is_ref   = req.cmd == CMD_REF;
  wire is_read  = req.cmd == CMD_READ;
  wire is_write = req.cmd == CMD_WRITE;

  // blocking checks per command kind
  // a counter loaded with n on the issue edge reaches zero n edges
  // later, so the next conflicting command goes one edge after that:
  // the spacing is n plus one, erring on the safe side by a cycle.
  // writes are never held back here; only reads see turnaround
  logic bank_busy;
  logic ref_bank_busy;
  logic w2r_busy;
  always_comb
  begin
    ref_bank_busy = 1'b0;
    w2r_busy      = 1'b0;
    for (int b = 0; b < BANKS; b++)
      if (bank_cnt_reg[req.rank][b] != 8'h0)
        ref_bank_busy = 1'b1;
    for (int r = 0; r < RANKS; r++)
      if (r != int'(req.rank) && rank_w2r_cnt_reg[r] != 8'h0)
        w2r_busy = 1'b1;
  end
  assign bank_busy = bank_cnt_reg[req.rank][req.bank] != 8'h0;

  wire rank_gap = rank_act_cnt_reg[req.rank] != 8'h0 ||
                  rank_ref_cnt_reg[req.rank] != 8'h0;
  assign grant = req.valid &&
    !((is_act && (bank_busy || rank_gap)) ||
      (is_ref && (ref_bank_busy || rank_gap)) ||
      (is_read && w2r_busy));
  wire issued = grant;

  // per-bank/rank down counters, reloaded on issued activates, refreshes and writes
  // rank timers: activate spacing, refresh recovery, write turnaround.
  // the turnaround timer is checked against other ranks only, since
  // dimm grouping is not known here every other rank is treated alike
  generate
    for (genvar r = 0; r < RANKS; r++)
    begin : g_rank
      wire hit_r = issued && req.rank == 2'(r);
      always_ff @(posedge sys_clk)
      begin
        if (reset)
        begin
          rank_act_cnt_reg[r] <= 8'h0;
          rank_ref_cnt_reg[r] <= 8'h0;
          rank_w2r_cnt_reg[r] <= 8'h0;
        end
        else
        begin
          if (hit_r && is_act)
            rank_act_cnt_reg[r] <= {4'h0, bank_to_bank_spacing};
          else if (rank_act_cnt_reg[r] != 8'h0)
            rank_act_cnt_reg[r] <= rank_act_cnt_reg[r] - 8'h1;
          if (hit_r && is_ref)
            rank_ref_cnt_reg[r] <= refresh_cycle_spacing;
          else if (rank_ref_cnt_reg[r] != 8'h0)
            rank_ref_cnt_reg[r] <= rank_ref_cnt_reg[r] - 8'h1;
          if (hit_r && is_write)
            rank_w2r_cnt_reg[r] <= {5'h0, write_read_other_rank_spacing};
          else if (rank_w2r_cnt_reg[r] != 8'h0)
            rank_w2r_cnt_reg[r] <= rank_w2r_cnt_reg[r] - 8'h1;
        end
      end
      for (genvar b = 0; b < BANKS; b++)
      begin : g_bank
        wire hit_b = hit_r && req.bank == 3'(b);
        logic [7:0] remain;
        assign remain = bank_cnt_reg[r][b] == 8'h0 ? 8'h0 :
                        bank_cnt_reg[r][b] - 8'h1;
        // write-recovery only extends a wait, never shortens a row cycle
        wire [7:0] wrc_load = {2'h0, write_recovery_cycle_spacing};
        always_ff @(posedge sys_clk)
        begin
          if (reset)
          begin
            bank_cnt_reg[r][b] <= 8'h0;
            act_open_reg[r][b] <= 1'b0;
          end
          else if (hit_b && is_act)
          begin
            bank_cnt_reg[r][b] <= {2'h0, same_bank_row_cycle};
            act_open_reg[r][b] <= 1'b1;
          end
          else if (hit_b && is_write && req.auto_close && act_open_reg[r][b])
          begin
            bank_cnt_reg[r][b] <= remain > wrc_load ? remain : wrc_load;
            act_open_reg[r][b] <= 1'b0;
          end
          else
            bank_cnt_reg[r][b] <= remain;
        end
      end
    end
  endgenerate

  // refresh pacing: one step count per 3.9 us unit, one tick per interval
  // the step counter only runs with refresh on; turning the field to
  // zero clears it at once, so a later enable starts a full interval.
  // all ranks share one tick; the scheduler spreads the refreshes
  logic [8:0] step_cnt_reg;
  logic [1:0] unit_cnt_reg;
  logic [3:0] owed_reg [RANKS];
  wire ref_on = refresh_interval != 2'h0;
  wire step_done = step_cnt_reg == 9'(REF_STEP_CYCLES - 1);
  wire interval_done = step_done && unit_cnt_reg == refresh_interval - 2'h1;

  always_ff @(posedge sys_clk)
  begin
    if (reset || !ref_on)
    begin
      step_cnt_reg <= 9'h0;
      unit_cnt_reg <= 2'h0;
    end
    else if (step_done)
    begin
      step_cnt_reg <= 9'h0;
      unit_cnt_reg <= interval_done ? 2'h0 : unit_cnt_reg + 2'h1;
    end
    else
      step_cnt_reg <= step_cnt_reg + 9'h1;
  end

  // owed refreshes per rank, up to nine, so bursts may catch up on average
  // a tick and an issued refresh in one cycle cancel out; at nine the
  // count saturates and further ticks are lost, which the scheduler
  // must avoid by draining the owed count in time
  generate
    for (genvar r = 0; r < RANKS; r++)
    begin : g_owed
      wire done_r = issued && is_ref && req.rank == 2'(r);
      wire add_r = interval_done && owed_reg[r] != 4'h9;
      always_ff @(posedge sys_clk)
      begin
        if (reset || !ref_on)
          owed_reg[r] <= 4'h0;
        else if (add_r && !done_r)
          owed_reg[r] <= owed_reg[r] + 4'h1;
        else if (done_r && !add_r && owed_reg[r] != 4'h0)
          owed_reg[r] <= owed_reg[r] - 4'h1;
      end
      assign refresh_due[r] = owed_reg[r] != 4'h0;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- testbench/guard_monitor.sv ----
// concurrent checks on the command timing guard ports
// bound onto the guard; shadows both timing registers from the write port
`timescale 1ns/1ps
`default_nettype none
module guard_monitor
(
  input wire logic                       sys_clk,
  input wire logic                       reset,
  input wire logic                       reg_wr,
  input wire logic [7:0]                 reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic [31:0]                reg_rdata,
  input wire timing_guard_pkg::cmd_req_s req,
  input wire logic                       grant,
  input wire logic [3:0]                 refresh_due
);
  import timing_guard_pkg::*;
  logic [31:0] a_reg;
  logic [31:0] b_reg;
  // shadow copies, reserved bits dropped as the guard does
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      {a_reg, b_reg} <= '0;
    else if (reg_wr && reg_addr == TIMING_A_OFFSET)
      a_reg <= reg_wdata & TIMING_A_RW_MASK;
    else if (reg_wr && reg_addr == TIMING_B_OFFSET)
      b_reg <= reg_wdata & TIMING_B_RW_MASK;
  end
  // expected read word; unmapped reads as zero
  wire logic [31:0] rd_exp = reg_addr == TIMING_A_OFFSET ? a_reg :
                             reg_addr == TIMING_B_OFFSET ? b_reg : '0;
  wire logic        is_act = req.valid && req.cmd == CMD_ACT;
  wire logic        is_ref = req.valid && req.cmd == CMD_REF;
  wire logic        is_rd  = req.valid && req.cmd == CMD_READ;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_act_go; grant && req.cmd == CMD_ACT; endsequence
  sequence s_ref_go; grant && req.cmd == CMD_REF; endsequence
  sequence s_wr_go;  grant && req.cmd == CMD_WRITE; endsequence
  AST_ROW: assert property (s_act_go ##1 (is_act && a_reg[19:14] > 6'h1 &&
    req.rank == $past(req.rank) && req.bank == $past(req.bank)) |-> !grant)
    else $error("same bank activate granted early");
  AST_ROW_REF: assert property (s_act_go ##1 (is_ref &&
    a_reg[19:14] > 6'h1 && req.rank == $past(req.rank)) |-> !grant)
    else $error("refresh granted right after activate");
  AST_RRD: assert property (s_act_go ##1 (is_act && a_reg[5:2] > 4'h1 &&
    req.rank == $past(req.rank) && req.bank != $past(req.bank)) |-> !grant)
    else $error("other bank activate granted early");
  AST_RFC: assert property (s_ref_go ##1 ((is_act || is_ref) &&
    a_reg[13:6] > 8'h1 && req.rank == $past(req.rank)) |-> !grant)
    else $error("command granted early after refresh");
  AST_W2R: assert property (s_wr_go ##1 (is_rd && b_reg[18:16] > 3'h1 &&
    req.rank != $past(req.rank)) |-> !grant)
    else $error("other rank read granted early after write");
  AST_IDLE: assert property (!req.valid |-> !grant)
    else $error("grant without a request");
  AST_RDATA: assert property (reg_rdata == $past(rd_exp))
    else $error("register read data wrong");
  AST_REF_OFF: assert property ((a_reg[1:0] == 2'h0)[*3] |->
    refresh_due == 4'h0) else $error("refresh owed while disabled");
endmodule
`default_nettype wire

// ---- testbench/cmd_source.sv ----
// scheduler stand-in: offers up to three commands back to back
// span gives cycles from first to last grant; done pulses at the end
`timescale 1ns/1ps
`default_nettype none
module cmd_source
(
  input  wire logic                             sys_clk,
  input  wire logic                             reset,
  input  wire logic                             go,
  input  wire timing_guard_pkg::cmd_req_s [2:0] cmds,
  input  wire logic                             grant,
  output timing_guard_pkg::cmd_req_s            req,
  output logic                       [15:0]     span,
  output logic                                  done
);
  import timing_guard_pkg::*;
  logic [1:0]  idx_reg;
  logic [15:0] cyc_reg;
  // a request is held until the edge that samples grant high
  wire logic taken = req.valid && grant;
  wire logic more  = idx_reg != 2'h3 && cmds[idx_reg].valid;
  always_ff @(posedge sys_clk)
  begin
    done <= 1'b0;
    cyc_reg <= (taken && idx_reg == 2'h1) ? 16'h1 : cyc_reg + 16'h1;
    if (reset)
      req <= '0;
    else if (go)
      {req, idx_reg} <= {cmds[0], 2'h1};
    else if (taken && more)
      {req, idx_reg} <= {cmds[idx_reg], idx_reg + 2'h1};
    else if (taken)
      {req, done, span} <= {10'h0, 1'b1, idx_reg == 2'h1 ? 16'h0 : cyc_reg};
  end
endmodule
`default_nettype wire

// ---- testbench/tb_dram_command_timing_guard.sv ----
// self-checking bench for the command timing guard
// source model drives the command port; registers written directly
`timescale 1ns/1ps
`default_nettype none
module tb_dram_command_timing_guard;
  import timing_guard_pkg::*;
  logic             sys_clk = 1'b0;
  logic             reset = 1'b1;
  logic             reg_wr = 1'b0;
  logic             go = 1'b0;
  logic [7:0]       reg_addr = 8'h0;
  logic [31:0]      reg_wdata = 32'h0;
  cmd_req_s [2:0]   cmds = '0;
  wire logic [31:0] reg_rdata;
  wire logic [15:0] span;
  wire logic [3:0]  refresh_due;
  wire logic        grant;
  wire logic        done;
  wire cmd_req_s    req;
  int               failures = 0;
  int               tests_run = 0;
  always #5 sys_clk = ~sys_clk;
  dram_command_timing_guard dram_command_timing_guard_i (.sys_clk(sys_clk),
    .reset(reset), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .req(req),
    .grant(grant), .refresh_due(refresh_due));
  cmd_source cmd_source_i (.sys_clk(sys_clk), .reset(reset), .go(go),
    .cmds(cmds), .grant(grant), .req(req), .span(span), .done(done));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk) reg_addr <= a;
    @(posedge sys_clk) #1 chk(reg_rdata, exp);
  endtask
  function cmd_req_s c(dram_cmd_e k, logic [1:0] r, logic [2:0] b, logic ac);
    return {1'b1, k, r, b, ac};
  endfunction
  // offer commands back to back, then compare first-to-last grant span
  task run(input cmd_req_s c0, c1, c2, input logic [15:0] exp);
    @(posedge sys_clk) {cmds, go} <= {c2, c1, c0, 1'b1};
    @(posedge sys_clk) go <= 1'b0;
    for (int i = 0; i < 60 && done !== 1'b1; i++)
      @(posedge sys_clk) #1;
    chk({15'h0, done, span}, {15'h0, 1'b1, exp});
  endtask
  task test_regs;
    rd(TIMING_A_OFFSET, 32'h0);
    rd(TIMING_B_OFFSET, 32'h0);
    wr(TIMING_A_OFFSET, 32'hffff_ffff);
    rd(TIMING_A_OFFSET, 32'h7fff_ffff);
    wr(TIMING_B_OFFSET, 32'hffff_ffff);
    rd(TIMING_B_OFFSET, 32'h0007_ffff);
    wr(8'h50, 32'h1234_5678);
    rd(8'h50, 32'h0);
    // spacings held to the worst fitted module, refresh off
    wr(TIMING_A_OFFSET, {6'h0, 6'hc, 6'h6, 8'h09, 4'h3, 2'h0});
    wr(TIMING_B_OFFSET, {13'h0, 3'h5, 16'h0});
  endtask
  task test_bank;
    // a field of n holds the next command n plus one cycles
    run(c(CMD_ACT, 0, 0, 0), c(CMD_ACT, 0, 0, 0), c(CMD_REF, 0, 0, 0), 16'he);
    run(c(CMD_ACT, 1, 0, 0), c(CMD_ACT, 1, 1, 0), '0, 16'h4);
    run(c(CMD_ACT, 3, 2, 0), c(CMD_WRITE, 3, 2, 1), c(CMD_ACT, 3, 2, 0), 16'he);
  endtask
  task test_rank;
    run(c(CMD_REF, 2, 0, 0), c(CMD_ACT, 2, 3, 0), '0, 16'ha);
    run(c(CMD_WRITE, 0, 5, 0), c(CMD_READ, 1, 6, 0), '0, 16'h6);
  endtask
  task test_refresh;
    repeat (400) @(posedge sys_clk);
    chk(refresh_due, 32'h0);
    wr(TIMING_A_OFFSET, 32'h1);
    repeat (380) @(posedge sys_clk);
    chk(refresh_due, 32'h0);
    repeat (20) @(posedge sys_clk);
    chk(refresh_due, 32'hf);
    run(c(CMD_REF, 0, 0, 0), '0, '0, 16'h0);
    chk(refresh_due, 32'he);
    wr(TIMING_A_OFFSET, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk(refresh_due, 32'h0);
  endtask
  task give_verdict;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    test_regs;
    test_bank;
    test_rank;
    test_refresh;
    give_verdict;
  end
  // run needs about 910 cycles; allow some thirteen times that
  initial
  begin
    #120000;
    failures++;
    give_verdict;
  end
endmodule
bind dram_command_timing_guard guard_monitor guard_monitor_i (.sys_clk(sys_clk),
  .reset(reset), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .req(req), .grant(grant), .refresh_due(refresh_due));
`default_nettype wire
